/* File: hw/irsd_pkg.sv */
// Constants for the internal register space decoder
`default_nettype none
package irsd_pkg;
  localparam int          IRSD_NBLK      = 6;
  localparam int          IRSD_OFF_W     = 21;
  localparam int          IRSD_BASE_LSB  = 21;
  localparam logic [31:0] IRSD_BASE_RST  = 32'hFF40_0000;
  localparam logic [2:0]  IRSD_WORD_SIZE = 3'h4;
  localparam logic [1:0]  IRSD_ALIGN_OK  = 2'h0;

  // Block indices into the select vector
  localparam int IRSD_IDX_INTC  = 0;
  localparam int IRSD_IDX_GTM1  = 1;
  localparam int IRSD_IDX_PMC   = 2;
  localparam int IRSD_IDX_DSP1  = 3;
  localparam int IRSD_IDX_DSP2  = 4;
  localparam int IRSD_IDX_USB   = 5;

  // Window start, window size, sub-window stride and implemented bytes per sub-window
  localparam logic [20:0] IRSD_WIN_LO [IRSD_NBLK] = '{
    21'h0_0700, 21'h0_0500, 21'h0_0B00, 21'h0_4500, 21'h0_4900, 21'h2_3000};
  localparam logic [20:0] IRSD_WIN_SZ [IRSD_NBLK] = '{
    21'h0_0100, 21'h0_0100, 21'h0_0100, 21'h0_0200, 21'h0_0200, 21'h0_1000};
  localparam logic [20:0] IRSD_SUB_SZ [IRSD_NBLK] = '{
    21'h0_0100, 21'h0_0100, 21'h0_0100, 21'h0_0100, 21'h0_0100, 21'h0_1000};
  localparam logic [20:0] IRSD_IMPL_SZ [IRSD_NBLK] = '{
    21'h0_0080, 21'h0_0040, 21'h0_0014, 21'h0_0012, 21'h0_0012, 21'h0_0500};
endpackage
`default_nettype wire

/* File: hw/irsd_win_match.sv */
// Window match for one block of the internal register space
`default_nettype none
module irsd_win_match
  import irsd_pkg::*;
#(
  parameter logic [20:0] WIN_LO  = 21'h0_0000,
  parameter logic [20:0] WIN_SZ  = 21'h0_0100,
  parameter logic [20:0] SUB_SZ  = 21'h0_0100,
  parameter logic [20:0] IMPL_SZ = 21'h0_0004
)(
  input  wire logic [20:0] offset_i,  // Offset inside the register region
  output logic             win_o,     // Offset inside the whole window
  output logic             impl_o     // Offset on an implemented byte
);
  logic [20:0] rel;
  logic [20:0] sub;

  assign rel    = offset_i - WIN_LO;
  // Strides are powers of two, so the sub-window offset is a mask
  assign sub    = rel & (SUB_SZ - 21'h00_0001);
  assign win_o  = (offset_i >= WIN_LO) && (rel < WIN_SZ);
  assign impl_o = win_o && (sub < IMPL_SZ);
endmodule
`default_nettype wire

/* File: hw/irsd_decoder.sv */
// Internal register space decoder: base register, window decode, read return
`default_nettype none

module irsd_decoder
  import irsd_pkg::*;
(
  input  wire logic                   clk_i,          // Core bus clock
  input  wire logic                   sys_rst_i,      // Synchronous reset, active high
  input  wire logic                   base_wr_i,      // Load the base register
  input  wire logic [31:0]            base_wdata_i,   // New base value
  output logic      [31:0]            base_o,         // Base register read-back
  input  wire logic                   req_valid_i,    // Access request
  input  wire logic                   req_write_i,    // 1 write, 0 read
  input  wire logic [31:0]            req_addr_i,     // Local byte address
  input  wire logic [2:0]             req_size_i,     // Access size in bytes
  input  wire logic [31:0]            req_wdata_i,    // Write data
  output logic      [IRSD_NBLK-1:0]   blk_sel_o,      // One-hot block select
  output logic                        blk_valid_o,    // Forwarded access strobe
  output logic                        blk_write_o,    // Forwarded direction
  output logic      [IRSD_OFF_W-1:0]  blk_offset_o,   // Offset inside the region
  output logic      [31:0]            blk_wdata_o,    // Forwarded write data
  input  wire logic [IRSD_NBLK*32-1:0] blk_rdata_i,   // Read data of every block
  output logic                        rsp_valid_o,    // Access completed
  output logic      [31:0]            rsp_rdata_o,    // Read data
  output logic                        rsp_size_err_o, // Size or alignment error
  output logic                        rsp_reserved_o, // Reserved location hit
  output logic                        rsp_miss_o      // Address outside the region
);
  logic [31:IRSD_BASE_LSB]  base_hi;
  logic [IRSD_OFF_W-1:0]    offset;
  logic                     in_region;
  logic                     size_ok;
  logic [IRSD_NBLK-1:0]     win_hit;
  logic [IRSD_NBLK-1:0]     impl_hit;
  logic [IRSD_NBLK-1:0]     next_sel;
  logic                     fwd;
  logic                     s1_valid;
  logic                     s1_read;
  logic                     s1_err;
  logic                     s1_resv;
  logic                     s1_miss;
  logic [31:0]              next_rdata;

  // Region is aligned to its size, so only the upper base bits are stored
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      base_hi <= IRSD_BASE_RST[31:IRSD_BASE_LSB];
    else if (base_wr_i)
      base_hi <= base_wdata_i[31:IRSD_BASE_LSB];
  end

  // Low base bits have no storage and read as zero
  assign base_o = {base_hi, {IRSD_BASE_LSB{1'b0}}};

  // With an aligned base the subtraction reduces to the low address bits
  assign in_region = (req_addr_i[31:IRSD_BASE_LSB] == base_hi);
  assign offset    = req_addr_i[IRSD_OFF_W-1:0];
  assign size_ok   = (req_size_i == IRSD_WORD_SIZE) && (req_addr_i[1:0] == IRSD_ALIGN_OK);

  generate
    for (genvar g = 0; g < IRSD_NBLK; g++)
    begin : g_win
      irsd_win_match #(
        .WIN_LO  (IRSD_WIN_LO[g]),
        .WIN_SZ  (IRSD_WIN_SZ[g]),
        .SUB_SZ  (IRSD_SUB_SZ[g]),
        .IMPL_SZ (IRSD_IMPL_SZ[g])
      ) u_match (
        .offset_i (offset),
        .win_o    (win_hit[g]),
        .impl_o   (impl_hit[g])
      );
    end
  endgenerate

  // Windows do not overlap, so at most one bit is set
  assign next_sel = (in_region && size_ok) ? impl_hit : '0;
  assign fwd      = req_valid_i && (next_sel != '0);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      blk_sel_o   <= '0;
      blk_valid_o <= 1'b0;
    end
    else
    begin
      blk_sel_o   <= fwd ? next_sel : '0;
      blk_valid_o <= fwd;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      blk_write_o  <= 1'b0;
      blk_offset_o <= '0;
      blk_wdata_o  <= '0;
    end
    else if (fwd)
    begin
      blk_write_o  <= req_write_i;
      blk_offset_o <= offset;
      blk_wdata_o  <= req_wdata_i;
    end
  end

  // Classification of every request, forwarded or not
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_valid <= 1'b0;
      s1_read  <= 1'b0;
      s1_err   <= 1'b0;
      s1_resv  <= 1'b0;
      s1_miss  <= 1'b0;
    end
    else
    begin
      s1_valid <= req_valid_i;
      s1_read  <= req_valid_i && !req_write_i;
      s1_miss  <= req_valid_i && !in_region;
      s1_err   <= req_valid_i && in_region && !size_ok;
      // Reserved reads and writes are flagged here; neither reaches any block
      s1_resv  <= req_valid_i && in_region && size_ok && (impl_hit == '0);
    end
  end

  // Read mux; anything not read from a selected block returns zero
  always_comb
  begin
    next_rdata = '0;
    for (int i = 0; i < IRSD_NBLK; i++)
    begin
      if (blk_sel_o[i] && s1_read)
        next_rdata = blk_rdata_i[i*32 +: 32];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rsp_valid_o    <= 1'b0;
      rsp_rdata_o    <= '0;
      rsp_size_err_o <= 1'b0;
      rsp_reserved_o <= 1'b0;
      rsp_miss_o     <= 1'b0;
    end
    else
    begin
      rsp_valid_o    <= s1_valid;
      rsp_rdata_o    <= next_rdata;
      rsp_size_err_o <= s1_err;
      rsp_reserved_o <= s1_resv;
      rsp_miss_o     <= s1_miss;
    end
  end
endmodule
`default_nettype wire

/* File: dv/irsd_decoder_checker.sv */
// Concurrent checks on the register space decoder ports
`default_nettype none
module irsd_decoder_checker
  import irsd_pkg::*;
(
  input wire logic                 clk_i,          // Core bus clock
  input wire logic                 sys_rst_i,      // Synchronous reset
  input wire logic                 base_wr_i,      // Base load
  input wire logic                 req_valid_i,    // Access request
  input wire logic [31:0]          base_wdata_i,   // New base value
  input wire logic [31:0]          base_o,         // Base read-back
  input wire logic [31:0]          req_addr_i,     // Access address
  input wire logic [31:0]          rsp_rdata_o,    // Read data
  input wire logic [2:0]           req_size_i,     // Access size
  input wire logic [IRSD_NBLK-1:0] blk_sel_o,      // Block select
  input wire logic [20:0]          blk_offset_o,   // Forwarded offset
  input wire logic                 blk_valid_o,    // Forward strobe
  input wire logic                 rsp_valid_o,    // Response strobe
  input wire logic                 rsp_size_err_o, // Size error flag
  input wire logic                 rsp_reserved_o, // Reserved flag
  input wire logic                 rsp_miss_o      // Miss flag
);
  wire logic in_r = req_addr_i[31:21] == base_o[31:21];
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  rsp_every_a: assert property (req_valid_i |-> ##2 rsp_valid_o)
    else $error("no response");
  region_miss_a: assert property (req_valid_i && !in_r |-> ##1 !blk_valid_o ##1 rsp_miss_o)
    else $error("miss not flagged");
  size_err_a: assert property (req_valid_i && in_r && req_size_i != 3'h4
    |-> ##1 !blk_valid_o ##1 rsp_size_err_o) else $error("size error lost");
  sel_onehot_a: assert property (blk_valid_o |-> $onehot(blk_sel_o)
    ##1 rsp_valid_o && !rsp_reserved_o && !rsp_miss_o) else $error("bad select");
  resv_drop_a: assert property (rsp_reserved_o |-> !$past(blk_valid_o) && rsp_rdata_o == 0)
    else $error("reserved forwarded");
  base_rst_a: assert property ($fell(sys_rst_i) |-> base_o == 32'hFF40_0000)
    else $error("base reset value");
  base_load_a: assert property (base_wr_i |=> base_o == ($past(base_wdata_i) & 32'hFFE0_0000))
    else $error("base load");
  offset_fwd_a: assert property (blk_valid_o |-> $past(req_valid_i)
    && blk_offset_o == $past(req_addr_i[20:0])) else $error("offset");
endmodule
bind irsd_decoder irsd_decoder_checker i_chk (.*);
`default_nettype wire

/* File: dv/irsd_bank_model.sv */
// Peripheral register banks answering forwarded reads
`default_nettype none
module irsd_bank_model
  import irsd_pkg::*;
(
  input  wire logic                   clk_i,    // Core bus clock
  input  wire logic                   valid_i,  // Forwarded strobe
  input  wire logic [IRSD_NBLK-1:0]   sel_i,    // Block select
  input  wire logic [20:0]            offset_i, // Region offset
  output logic      [IRSD_NBLK*32-1:0] rdata_o  // Read data of all blocks
);
  // Unselected banks show churn so a late sample never looks right
  logic [31:0] noise = 32'h1234_5678;
  always @(posedge clk_i)
    noise <= ~noise + 32'h3;
  always_comb
    for (int i = 0; i < IRSD_NBLK; i++)
      rdata_o[i*32+:32] = (valid_i && sel_i[i]) ? {11'h0A5, offset_i} : noise;
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Testbench for the register space decoder
`default_nettype none
module tb_top
  import irsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, base_wr_i = 0, req_valid_i = 0, req_write_i = 0;
  logic [31:0] base_wdata_i = 0, req_addr_i = 0, req_wdata_i = 0, base_o, blk_wdata_o, rsp_rdata_o;
  logic [2:0] req_size_i = 3'h4;
  logic [IRSD_NBLK-1:0] blk_sel_o;
  logic [IRSD_NBLK*32-1:0] blk_rdata_i;
  logic [20:0] blk_offset_o;
  logic blk_valid_o, blk_write_o, rsp_valid_o, rsp_size_err_o, rsp_reserved_o, rsp_miss_o;
  int fail_count = 0, cmp_count = 0;
  irsd_decoder i_dut (.*);
  irsd_bank_model i_bank (.clk_i(clk_i), .valid_i(blk_valid_o), .sel_i(blk_sel_o),
    .offset_i(blk_offset_o), .rdata_o(blk_rdata_i));
  initial
    forever #10 clk_i = ~clk_i;
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic results;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One access; blk below zero means nothing may be forwarded; fl is {miss, reserved, size}
  task automatic acc(input logic [31:0] a, input logic [2:0] sz, input logic w, input int blk,
                     input logic [2:0] fl);
    @(posedge clk_i);
    #1 req_valid_i = 1;
    req_addr_i = a;
    req_size_i = sz;
    req_write_i = w;
    // Upper bits above the offset stay zero, as for reserved fields
    req_wdata_i = {11'h000, a[20:0]};
    @(posedge clk_i);
    #1 req_valid_i = 0;
    chk(blk_valid_o === (blk >= 0), "forward");
    if (blk >= 0)
    begin
      chk(blk_sel_o === IRSD_NBLK'(1) << blk && blk_write_o === w, "select");
      chk(blk_wdata_o === req_wdata_i, "forwarded data");
    end
    @(posedge clk_i);
    #1 chk(rsp_valid_o === 1'b1 && {rsp_miss_o, rsp_reserved_o, rsp_size_err_o} === fl, "flags");
    chk(rsp_rdata_o === ((blk >= 0 && !w) ? {11'h0A5, a[20:0]} : 32'h0), "data");
  endtask
  task automatic t_blocks;
    logic [31:0] lo;
    logic [31:0] lst;
    for (int i = 0; i < IRSD_NBLK; i++)
    begin
      lo = 32'hFF40_0000 + 32'(IRSD_WIN_LO[i]);
      // Last aligned word starting on an implemented byte; serial banks end mid-word
      lst = lo + ((32'(IRSD_IMPL_SZ[i]) - 32'h1) & 32'hFFFF_FFFC);
      acc(lo, 3'h4, 0, i, 3'h0);
      acc(lst, 3'h4, 1, i, 3'h0);
      acc(lst, 3'h4, 0, i, 3'h0);
      acc(lst + 32'h4, 3'h4, 0, -1, 3'h2);
      if (i == 3 || i == 4)
        acc(lo + 32'h100, 3'h4, 0, i, 3'h0);
    end
  endtask
  task automatic t_size;
    acc(32'hFF40_0700, 3'h2, 0, -1, 3'h1);
    acc(32'hFF40_0700, 3'h1, 1, -1, 3'h1);
    acc(32'hFF40_0500, 3'h0, 0, -1, 3'h1);
    acc(32'hFF40_0702, 3'h4, 0, -1, 3'h1);
    // Reserved locations are only ever read, never written
    acc(32'hFF40_0600, 3'h4, 0, -1, 3'h2);
  endtask
  task automatic t_reloc;
    @(posedge clk_i);
    #1 base_wr_i = 1;
    base_wdata_i = 32'h8001_2345;
    @(posedge clk_i);
    #1 base_wr_i = 0;
    chk(base_o === 32'h8000_0000, "base");
    acc(32'hFF40_0700, 3'h4, 0, -1, 3'h4);
    acc(32'h8000_0700, 3'h4, 0, 0, 3'h0);
    acc(32'h801F_FFFC, 3'h4, 0, -1, 3'h2);
    acc(32'h8020_0000, 3'h4, 0, -1, 3'h4);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 0;
    chk(base_o === 32'hFF40_0000, "reset base");
    t_blocks();
    t_size();
    t_reloc();
    results();
  end
endmodule
`default_nettype wire
